//--- rtl/ptm_paired_timer.v
// Paired 16-bit timer that also runs as one 32-bit timer or synchronous counter
`timescale 1ns/10ps
`include "ptm_regs.vh"
module ptm_paired_timer #(
    parameter PS_WIDTH = 8
) (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // Software access port
    input wire wr_strobe,
    input wire rd_strobe,
    input wire [2:0] word_select,
    input wire [15:0] wr_data,
    output reg [15:0] rd_data,
    // Interrupt controller side
    input wire high_half_event_clear,
    input wire high_half_event_enable,
    output reg high_half_event_flag,
    output wire high_half_irq,
    output reg low_half_event_flag,
    // CPU power state
    input wire cpu_idle,
    input wire cpu_sleep,
    // Pins
    input wire gate_clock_pin,
    input wire high_clock_pin,
    // ADC trigger
    output reg adc_trigger
);
    // Software-visible words
    reg [15:0] low_half_control_reg;
    reg [15:0] high_half_control_reg;
    reg [15:0] low_count_word_reg;
    reg [15:0] high_count_word_reg;
    reg [15:0] high_word_holding_reg;
    reg [15:0] low_period_word_reg;
    reg [15:0] high_period_word_reg;
    // Pin pipeline and low half resync stage
    reg [2:0] low_pin_sync_reg;
    reg [2:0] high_pin_sync_reg;
    reg low_pin_reg;
    reg high_pin_reg;
    reg low_ps_sync_reg;

    // Pin synchronisers: change counts once stages two and three agree
    always @(posedge mclk) begin
        if (sys_rst) begin
            low_pin_sync_reg <= 3'b000;
            high_pin_sync_reg <= 3'b000;
            low_pin_reg <= 1'b0;
            high_pin_reg <= 1'b0;
        end else begin
            low_pin_sync_reg <= {low_pin_sync_reg[1:0], gate_clock_pin};
            high_pin_sync_reg <= {high_pin_sync_reg[1:0], high_clock_pin};
            if (low_pin_sync_reg[1] == low_pin_sync_reg[2]) begin
                low_pin_reg <= low_pin_sync_reg[2];
            end
            if (high_pin_sync_reg[1] == high_pin_sync_reg[2]) begin
                high_pin_reg <= high_pin_sync_reg[2];
            end
        end
    end

    // Edge detection on the filtered pin levels
    reg low_pin_d_reg;
    reg high_pin_d_reg;
    always @(posedge mclk) begin
        if (sys_rst) begin
            low_pin_d_reg <= 1'b0;
            high_pin_d_reg <= 1'b0;
        end else begin
            low_pin_d_reg <= low_pin_reg;
            high_pin_d_reg <= high_pin_reg;
        end
    end
    // Rising edges count, a gate fall ends accumulation
    wire low_pin_rise = low_pin_reg & ~low_pin_d_reg;
    wire high_pin_rise = high_pin_reg & ~high_pin_d_reg;
    wire low_gate_fall = ~low_pin_reg & low_pin_d_reg;

    // Control field decode
    wire wide = low_half_control_reg[`PTM_BIT_WIDE];
    wire lo_run = low_half_control_reg[`PTM_BIT_RUN];
    wire lo_idle_stop = low_half_control_reg[`PTM_BIT_IDLE_STOP];
    wire lo_gate = low_half_control_reg[`PTM_BIT_GATE];
    wire lo_ext = low_half_control_reg[`PTM_BIT_CLK_SRC];
    wire hi_run = high_half_control_reg[`PTM_BIT_RUN];
    wire hi_idle_stop = high_half_control_reg[`PTM_BIT_IDLE_STOP];
    wire hi_ext = high_half_control_reg[`PTM_BIT_CLK_SRC];
    // High half gate bit is never decoded
    wire lo_gated = lo_gate & ~lo_ext;

    // Sleep stops every tick source, pin ticks included; idle stops only with idle-stop set
    wire lo_alive = ~cpu_sleep & ~(cpu_idle & lo_idle_stop);
    wire hi_alive = ~cpu_sleep & ~(cpu_idle & hi_idle_stop);

    // Tick sources before prescaling
    wire lo_src = lo_ext ? low_pin_rise : (lo_gated ? low_pin_reg : 1'b1);
    wire hi_src = hi_ext ? high_pin_rise : 1'b1;

    // Software write decode
    wire wr_low_count = wr_strobe & (word_select == `PTM_SEL_LOW_COUNT);
    wire wr_holding = wr_strobe & (word_select == `PTM_SEL_HOLDING);
    wire wr_high_count = wr_strobe & (word_select == `PTM_SEL_HIGH_COUNT);
    wire wr_low_period = wr_strobe & (word_select == `PTM_SEL_LOW_PERIOD);
    wire wr_high_period = wr_strobe & (word_select == `PTM_SEL_HIGH_PERIOD);
    wire wr_low_ctrl = wr_strobe & (word_select == `PTM_SEL_LOW_CTRL);
    wire wr_high_ctrl = wr_strobe & (word_select == `PTM_SEL_HIGH_CTRL);

    // Prescaler clears; wide mode has both count words feed the low prescaler
    wire lo_ps_clear = wr_low_count | wr_low_ctrl | (wide & (wr_high_count | wr_high_ctrl));
    wire hi_ps_clear = wr_high_count | wr_high_ctrl;

    // Divided ticks, one per prescaler
    wire lo_ps_tick;
    wire hi_ps_tick;

    // Low half prescaler, also the wide-mode source
    ptm_prescaler #(
        .WIDTH(PS_WIDTH)
    ) u_low_ps (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run_enable(lo_run),
        .clear(lo_ps_clear),
        .prescale_select(low_half_control_reg[`PTM_BIT_PS_HI:`PTM_BIT_PS_LO]),
        .tick_in(lo_src & lo_alive),
        .tick_out(lo_ps_tick)
    );

    // High half prescaler, idle in wide mode
    ptm_prescaler #(
        .WIDTH(PS_WIDTH)
    ) u_high_ps (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .run_enable(hi_run & ~wide),
        .clear(hi_ps_clear),
        .prescale_select(high_half_control_reg[`PTM_BIT_PS_HI:`PTM_BIT_PS_LO]),
        .tick_in(hi_src & hi_alive),
        .tick_out(hi_ps_tick)
    );

    // Low half output resynchronised; costs one cycle of latency
    always @(posedge mclk) begin
        if (sys_rst) begin
            low_ps_sync_reg <= 1'b0;
        end else begin
            low_ps_sync_reg <= lo_ps_tick & ~lo_ps_clear;
        end
    end

    // Count enables per configuration
    // A clearing write in the tick cycle drops the tick, as in the low half
    wire hi_tick_ok = hi_ps_tick & ~hi_ps_clear;
    wire lo_inc = lo_run & low_ps_sync_reg;
    wire hi_inc = hi_run & hi_tick_ok & ~wide;

    // Match detection
    wire [31:0] count32 = {high_count_word_reg, low_count_word_reg};
    wire [31:0] period32 = {high_period_word_reg, low_period_word_reg};
    wire match32 = (count32 == period32);
    wire lo_match16 = (low_count_word_reg == low_period_word_reg);
    wire hi_match16 = (high_count_word_reg == high_period_word_reg);
    wire wide_wrap = wide & lo_inc & match32;
    wire lo_wrap = ~wide & lo_inc & lo_match16;
    wire hi_wrap = hi_inc & hi_match16;

    // Count words: only counting, period wrap or a direct write change them
    // Wide mode: a low word write also loads the high word from holding
    always @(posedge mclk) begin
        if (sys_rst) begin
            low_count_word_reg <= `PTM_RST_COUNT;
            high_count_word_reg <= `PTM_RST_COUNT;
        end else begin
            if (wr_low_count) begin
                low_count_word_reg <= wr_data;
            end else if (wide_wrap | lo_wrap) begin
                low_count_word_reg <= 16'h0000;
            end else if (lo_inc) begin
                low_count_word_reg <= low_count_word_reg + 16'h0001;
            end
            if (wide & wr_low_count) begin
                high_count_word_reg <= high_word_holding_reg;
            end else if (wr_high_count) begin
                high_count_word_reg <= wr_data;
            end else if (wide_wrap | hi_wrap) begin
                high_count_word_reg <= 16'h0000;
            end else if (wide & lo_inc & (low_count_word_reg == 16'hFFFF)) begin
                high_count_word_reg <= high_count_word_reg + 16'h0001;
            end else if (hi_inc) begin
                high_count_word_reg <= high_count_word_reg + 16'h0001;
            end
        end
    end

    // Control and period registers; control writes leave counts alone
    always @(posedge mclk) begin
        if (sys_rst) begin
            low_half_control_reg <= `PTM_RST_CTRL;
            high_half_control_reg <= `PTM_RST_CTRL;
            low_period_word_reg <= `PTM_RST_PERIOD;
            high_period_word_reg <= `PTM_RST_PERIOD;
        end else begin
            if (wr_low_ctrl) begin
                low_half_control_reg <= wr_data;
            end
            if (wr_high_ctrl) begin
                high_half_control_reg <= wr_data;
            end
            if (wr_low_period) begin
                low_period_word_reg <= wr_data;
            end
            if (wr_high_period) begin
                high_period_word_reg <= wr_data;
            end
        end
    end

    // Holding register: written by software, loaded by a low count read
    always @(posedge mclk) begin
        if (sys_rst) begin
            high_word_holding_reg <= `PTM_RST_COUNT;
        end else if (wr_holding) begin
            high_word_holding_reg <= wr_data;
        end else if (rd_strobe & (word_select == `PTM_SEL_LOW_COUNT)) begin
            high_word_holding_reg <= high_count_word_reg;
        end
    end

    // Read data registered, valid the cycle after the strobe
    // Unused select reads as zero; writes to it are dropped
    always @(posedge mclk) begin
        if (sys_rst) begin
            rd_data <= 16'h0000;
        end else if (rd_strobe) begin
            case (word_select)
                `PTM_SEL_LOW_COUNT: rd_data <= low_count_word_reg;
                `PTM_SEL_HOLDING: rd_data <= high_word_holding_reg;
                `PTM_SEL_HIGH_COUNT: rd_data <= high_count_word_reg;
                `PTM_SEL_LOW_PERIOD: rd_data <= low_period_word_reg;
                `PTM_SEL_HIGH_PERIOD: rd_data <= high_period_word_reg;
                `PTM_SEL_LOW_CTRL: rd_data <= low_half_control_reg;
                `PTM_SEL_HIGH_CTRL: rd_data <= high_half_control_reg;
                default: rd_data <= 16'h0000;
            endcase
        end
    end

    // Gate fall ends accumulation; counts stay where they stopped
    wire gate_end = lo_run & lo_gated & low_gate_fall & lo_alive;
    // Split mode: each half reports its own match; the gate belongs to the low half
    wire hi_event = wide ? (wide_wrap | gate_end) : hi_wrap;
    wire lo_event = ~wide & (lo_wrap | gate_end);

    // Event flags: a set in the clear cycle wins
    always @(posedge mclk) begin
        if (sys_rst) begin
            high_half_event_flag <= 1'b0;
            low_half_event_flag <= 1'b0;
        end else begin
            high_half_event_flag <= hi_event | (high_half_event_flag & ~high_half_event_clear);
            low_half_event_flag <= lo_event | (low_half_event_flag & ~high_half_event_clear);
        end
    end

    // Request follows the flag while enabled
    assign high_half_irq = high_half_event_flag & high_half_event_enable;

    // ADC trigger pulse from the high half match
    always @(posedge mclk) begin
        if (sys_rst) begin
            adc_trigger <= 1'b0;
        end else begin
            adc_trigger <= wide_wrap | hi_wrap;
        end
    end
endmodule // ptm_paired_timer

//--- pkg/ptm_regs.vh
// Register offsets, control field positions, reset values and timing constants of the paired timer
`ifndef PTM_REGS_VH
`define PTM_REGS_VH
// Word select codes for the software access port
`define PTM_SEL_LOW_COUNT 3'h0
`define PTM_SEL_HOLDING 3'h1
`define PTM_SEL_HIGH_COUNT 3'h2
`define PTM_SEL_LOW_PERIOD 3'h3
`define PTM_SEL_HIGH_PERIOD 3'h4
`define PTM_SEL_LOW_CTRL 3'h5
`define PTM_SEL_HIGH_CTRL 3'h6
// Control field positions
`define PTM_BIT_RUN 15
`define PTM_BIT_IDLE_STOP 13
`define PTM_BIT_GATE 6
`define PTM_BIT_PS_HI 5
`define PTM_BIT_PS_LO 4
`define PTM_BIT_WIDE 3
`define PTM_BIT_CLK_SRC 1
// Reset values
`define PTM_RST_CTRL 16'h0000
`define PTM_RST_PERIOD 16'hFFFF
`define PTM_RST_COUNT 16'h0000
// Prescale ratios in divide counts
`define PTM_DIV_1 8'h00
`define PTM_DIV_8 8'h07
`define PTM_DIV_64 8'h3F
`define PTM_DIV_256 8'hFF
`endif

//--- rtl/ptm_prescaler.v
// Prescaler for one timer half: divides a tick stream by 1, 8, 64 or 256
`timescale 1ns/10ps
`include "ptm_regs.vh"
module ptm_prescaler #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // Control
    input wire run_enable,
    input wire clear,
    input wire [1:0] prescale_select,
    input wire tick_in,
    // Divided tick
    output wire tick_out
);
    reg [WIDTH-1:0] count_reg;
    reg [WIDTH-1:0] limit;

    // Terminal count per ratio
    always @* begin
        case (prescale_select)
            2'b00: limit = `PTM_DIV_1;
            2'b01: limit = `PTM_DIV_8;
            2'b10: limit = `PTM_DIV_64;
            default: limit = `PTM_DIV_256;
        endcase
    end

    assign tick_out = run_enable & tick_in & (count_reg == limit);

    // Halted prescaler (run_enable low) keeps the count, even through clears
    always @(posedge mclk) begin
        if (sys_rst) begin
            count_reg <= {WIDTH{1'b0}};
        end else if (run_enable) begin
            if (clear) begin
                count_reg <= {WIDTH{1'b0}};
            end else if (tick_in) begin
                count_reg <= (count_reg == limit) ? {WIDTH{1'b0}} : count_reg + 1'b1;
            end
        end
    end
endmodule // ptm_prescaler

//--- test/ptm_paired_timer_assertions.sv
// Port-level assertions for the paired timer
`timescale 1ns/10ps
module ptm_paired_timer_checker #(
    parameter PS_WIDTH = 8
) (
    // Clock and reset
    input wire mclk,
    input wire sys_rst,
    // Access port
    input wire wr_strobe,
    input wire rd_strobe,
    input wire [2:0] word_select,
    input wire [15:0] wr_data,
    input wire [15:0] rd_data,
    // Events
    input wire high_half_event_clear,
    input wire high_half_event_enable,
    input wire high_half_event_flag,
    input wire high_half_irq,
    input wire low_half_event_flag,
    // Power state, pins, trigger
    input wire cpu_idle,
    input wire cpu_sleep,
    input wire gate_clock_pin,
    input wire high_clock_pin,
    input wire adc_trigger
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Read of the unused select, and a sleep long enough to drain the count pipeline
    sequence s_void_read;
        rd_strobe && word_select == 3'h7;
    endsequence
    sequence s_long_sleep;
        cpu_sleep [*4];
    endsequence
    a_irq_from_flag: assert property (high_half_irq == (high_half_event_flag && high_half_event_enable))
        else $error("irq differs from flag and enable");
    a_flag_stays_set: assert property (high_half_event_flag && !high_half_event_clear |=> high_half_event_flag)
        else $error("event flag dropped without clear");
    a_low_flag_sticky: assert property (low_half_event_flag && !high_half_event_clear |=> low_half_event_flag)
        else $error("low flag dropped without clear");
    a_trig_single_pulse: assert property (adc_trigger |=> !adc_trigger)
        else $error("trigger longer than one cycle");
    a_trig_sets_flag: assert property (adc_trigger |-> high_half_event_flag)
        else $error("trigger without event flag");
    a_sleep_no_trig: assert property (s_long_sleep |-> !adc_trigger)
        else $error("trigger while asleep");
    a_void_read_zero: assert property (s_void_read |=> rd_data == 16'h0000)
        else $error("unused select read nonzero");
    a_read_data_holds: assert property (!rd_strobe && !$past(rd_strobe) |=> $stable(rd_data))
        else $error("read data moved without read");
    a_reset_clears: assert property (disable iff (1'b0) sys_rst |=> !high_half_event_flag && !adc_trigger)
        else $error("reset left outputs set");
endmodule // ptm_paired_timer_checker

//--- test/ptm_pin_model.sv
// Behavioural source of an external clock or gate on one timer pin
`timescale 1ns/10ps
module ptm_pin_model #(
    parameter HALF = 6
) (
    // Clock
    input wire mclk,
    // Commands from the bench
    input wire start,
    input wire [7:0] edges,
    input wire [7:0] gate_len,
    // Pin and status
    output reg pin,
    output reg busy
);
    initial begin
        pin = 1'b0;
        busy = 1'b0;
    end
    // Edges held long enough for the pin filter; no edges asked means one gate pulse
    always begin
        @(posedge mclk);
        if (start) begin
            busy <= 1'b1;
            if (edges == 8'h00) begin
                pin <= 1'b1;
                repeat (gate_len) @(posedge mclk);
                pin <= 1'b0;
            end else begin
                repeat (edges) begin
                    pin <= 1'b1;
                    repeat (HALF) @(posedge mclk);
                    pin <= 1'b0;
                    repeat (HALF) @(posedge mclk);
                end
            end
            busy <= 1'b0;
        end
    end
endmodule // ptm_pin_model

//--- test/paired_timer_32bit_tb_top.sv
// Self-checking bench for the paired timer
`timescale 1ns/10ps
module paired_timer_32bit_tb_top;
    reg mclk, sys_rst, wr_strobe, rd_strobe, clr, en, idle, sleep, g_start, h_start;
    reg [2:0] word_select;
    reg [15:0] wr_data, v, w;
    reg [7:0] edges, glen;
    wire [15:0] rd_data;
    wire flag, irq, lflag, trig, gpin, hpin, g_busy, h_busy;
    integer mismatches, samples_checked, i;
    ptm_paired_timer dut_u (.mclk(mclk), .sys_rst(sys_rst), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .word_select(word_select), .wr_data(wr_data), .rd_data(rd_data), .high_half_event_clear(clr),
        .high_half_event_enable(en), .high_half_event_flag(flag), .high_half_irq(irq),
        .low_half_event_flag(lflag), .cpu_idle(idle), .cpu_sleep(sleep), .gate_clock_pin(gpin),
        .high_clock_pin(hpin), .adc_trigger(trig));
    ptm_pin_model gate_u (.mclk(mclk), .start(g_start), .edges(edges), .gate_len(glen), .pin(gpin), .busy(g_busy));
    ptm_pin_model high_u (.mclk(mclk), .start(h_start), .edges(edges), .gate_len(glen), .pin(hpin), .busy(h_busy));
    // 100 ns clock
    always #50 mclk = ~mclk;
    task check(input [15:0] seen, input [15:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== exp) begin
                mismatches = mismatches + 1;
                $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task wr(input [2:0] s, input [15:0] d);
        begin
            @(posedge mclk);
            wr_strobe <= 1'b1;
            word_select <= s;
            wr_data <= d;
            @(posedge mclk);
            wr_strobe <= 1'b0;
        end
    endtask
    // Data is taken one full cycle after the strobe edge
    task rd(input [2:0] s, output [15:0] d);
        begin
            @(posedge mclk);
            rd_strobe <= 1'b1;
            word_select <= s;
            @(posedge mclk);
            rd_strobe <= 1'b0;
            @(posedge mclk);
            #1 d = rd_data;
        end
    endtask
    task rdc(input [2:0] s, input [15:0] e);
        begin
            rd(s, v);
            check(v, e);
        end
    endtask
    task drive(input h, input [7:0] e, input [7:0] l);
        begin
            @(posedge mclk);
            edges <= e;
            glen <= l;
            g_start <= !h;
            h_start <= h;
            @(posedge mclk);
            g_start <= 1'b0;
            h_start <= 1'b0;
            #1 i = 0;
            while ((g_busy || h_busy) && i < 600) begin
                @(posedge mclk);
                #1 i = i + 1;
            end
            check({15'h0000, g_busy | h_busy}, 16'h0000);
        end
    endtask
    // Bounded wait for one trigger pulse
    task wait_trig;
        begin
            #1 i = 0;
            while (!trig && i < 20) begin
                @(posedge mclk);
                #1 i = i + 1;
            end
            check({15'h0000, trig}, 16'h0001);
        end
    endtask
    task final_report;
        begin
            $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
            if (mismatches == 0 && samples_checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        {mclk, wr_strobe, rd_strobe, clr, idle, sleep, g_start, h_start} = 8'h00;
        sys_rst = 1'b1;
        en = 1'b1;
        word_select = 3'h0;
        wr_data = 16'h0000;
        edges = 8'h00;
        glen = 8'h00;
        mismatches = 0;
        samples_checked = 0;
        repeat (6) @(posedge mclk);
        sys_rst <= 1'b0;
        for (i = 0; i < 8; i = i + 1)
            rdc(i[2:0], (i == 3 || i == 4) ? 16'hFFFF : 16'h0000);
        wr(3'h7, 16'hAAAA);
        rdc(3'h7, 16'h0000);
        // Coherent 32-bit write then read, timer stopped
        wr(3'h5, 16'h0008);
        wr(3'h1, 16'h1234);
        wr(3'h0, 16'h5678);
        rdc(3'h2, 16'h1234);
        wr(3'h1, 16'h0000);
        wr(3'h5, 16'h0008);
        rdc(3'h0, 16'h5678);
        rdc(3'h1, 16'h1234);
        // Each prescale ratio over a 512 cycle window
        wr(3'h1, 16'h0000);
        wr(3'h6, 16'h8070);
        for (i = 0; i < 4; i = i + 1) begin
            wr(3'h5, 16'h8008 | (i << 4));
            wr(3'h0, 16'h0000);
            repeat (512) @(posedge mclk);
            rd(3'h0, v);
            w = 16'd512 >> ((i == 0) ? 0 : (i == 1) ? 3 : (i == 2) ? 6 : 8);
            check({15'h0000, v + 2 >= w && v <= w + 1}, 16'h0001);
        end
        wr(3'h5, 16'h800A);
        wr(3'h0, 16'h0000);
        drive(1'b0, 8'h05, 8'h00);
        repeat (10) @(posedge mclk);
        rdc(3'h0, 16'h0005);
        // Gate high for 40 cycles, then the count must hold
        wr(3'h5, 16'h8048);
        wr(3'h0, 16'h0000);
        drive(1'b0, 8'h00, 8'd40);
        repeat (8) @(posedge mclk);
        rd(3'h0, v);
        check({15'h0000, v >= 37 && v <= 41}, 16'h0001);
        rdc(3'h0, v);
        check({15'h0000, irq}, 16'h0001);
        @(posedge mclk) clr <= 1'b1;
        @(posedge mclk) clr <= 1'b0;
        @(posedge mclk) #1 check({15'h0000, flag}, 16'h0000);
        check({15'h0000, lflag}, 16'h0000);
        // Idle with stop bit set, then cleared, then sleep
        wr(3'h5, 16'hA008);
        idle <= 1'b1;
        rd(3'h0, v);
        repeat (20) @(posedge mclk);
        rdc(3'h0, v);
        wr(3'h5, 16'h8008);
        rd(3'h0, v);
        repeat (20) @(posedge mclk);
        rd(3'h0, w);
        check({15'h0000, w > v}, 16'h0001);
        @(posedge mclk) idle <= 1'b0;
        sleep <= 1'b1;
        rd(3'h0, v);
        repeat (20) @(posedge mclk);
        rdc(3'h0, v);
        @(posedge mclk) sleep <= 1'b0;
        // Wrap at a 32-bit period of 0x0001_0004
        wr(3'h3, 16'h0004);
        wr(3'h4, 16'h0001);
        wr(3'h1, 16'h0001);
        wr(3'h0, 16'h0000);
        wait_trig;
        check({15'h0000, flag}, 16'h0001);
        @(posedge mclk) en <= 1'b0;
        #1 check({15'h0000, irq}, 16'h0000);
        rd(3'h0, v);
        rdc(3'h1, 16'h0000);
        // Split: high half alone on internal ticks, then on its own pin
        wr(3'h5, 16'h0000);
        wr(3'h4, 16'h0003);
        wr(3'h2, 16'h0000);
        wr(3'h6, 16'h8000);
        wait_trig;
        wr(3'h6, 16'h0002);
        wr(3'h4, 16'hFFFF);
        wr(3'h2, 16'h0000);
        wr(3'h6, 16'h8002);
        drive(1'b1, 8'h03, 8'h00);
        repeat (10) @(posedge mclk);
        rdc(3'h2, 16'h0003);
        // High half alone with idle stop, then a split low half wrap sets its own flag
        wr(3'h6, 16'hA000);
        idle <= 1'b1;
        rd(3'h2, v);
        repeat (20) @(posedge mclk);
        rdc(3'h2, v);
        @(posedge mclk) idle <= 1'b0;
        wr(3'h0, 16'h0000);
        wr(3'h5, 16'h8000);
        repeat (12) @(posedge mclk);
        #1 check({15'h0000, lflag}, 16'h0001);
        // Mid-run reset returns the low period and low flag to their reset state
        @(posedge mclk) sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        rdc(3'h3, 16'hFFFF);
        check({15'h0000, lflag}, 16'h0000);
        final_report;
    end
    // Watchdog well past the expected run of about 2500 cycles
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches = mismatches + 1;
        final_report;
    end
endmodule // paired_timer_32bit_tb_top
bind ptm_paired_timer ptm_paired_timer_checker #(.PS_WIDTH(PS_WIDTH)) chk_u (.mclk(mclk), .sys_rst(sys_rst),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .word_select(word_select), .wr_data(wr_data), .rd_data(rd_data),
    .high_half_event_clear(high_half_event_clear), .high_half_event_enable(high_half_event_enable),
    .high_half_event_flag(high_half_event_flag), .high_half_irq(high_half_irq),
    .low_half_event_flag(low_half_event_flag), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .gate_clock_pin(gate_clock_pin), .high_clock_pin(high_clock_pin), .adc_trigger(adc_trigger));
